// ### csi_core.sv
// Functional notes
// - the 32 working registers appear at data addresses 0x00 to 0x1F.
// - X, Y, Z pointers are pairs 27:26, 29:28, 31:30, odd byte high.
// - byte push lowers stack pointer by one, byte pop raises it by one.
// - call and interrupt entry lower it by two; returns raise it by two.
// - stack pointer is two readable writable bytes, reset to top of memory.
// - a source is taken only with its enable and the global enable set.
// - lower vector wins among pending; reset first, then external request zero.
// - entry clears global enable; software may reset it; interrupt exit sets it.
// - vectoring to a flag source clears that source's flag in hardware.
// - writing one to a flag clears it, zero leaves it.
// - flags stay pending while disabled, then serve in priority order.
// - level sources request only while their condition is present.
// - after interrupt exit one main instruction runs before another entry.
// - status flags are neither saved on entry nor restored on exit.
// - disable instruction blocks any interrupt, even one in the same cycle.
// - after enable instruction the next instruction runs before any interrupt.
// - entry takes four cycles pushing the program counter, then the vector runs.
// - a multi-cycle instruction completes before interrupt entry begins.
// - waking from sleep adds four cycles to the entry response.
// - interrupt exit takes four cycles, pops the counter, raises pointer, sets enable.
// - the core runs directly on the chip clock with no division.
// - global enable is bit 7 of the status flags register.
module csi_core
  import csi_pkg::*;
#(
  parameter int          NUM_SRC  = 8,
  parameter logic [15:0] SP_RESET = csi_pkg::TOP_OF_DATA_MEMORY,
  // vector word addresses, index 0 = external request zero; reset sits at 0
  parameter logic [NUM_SRC*16-1:0] VEC_ADDRS = {16'h0010, 16'h000E, 16'h000C, 16'h000A,
                                                16'h0008, 16'h0006, 16'h0004, 16'h0002}
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  // working register read/write port (sequencer or data-space load/store)
  input  wire logic                   i_reg_we,
  input  wire logic [15:0]            i_reg_addr,
  input  wire logic [7:0]             i_reg_wdata,
  output logic      [7:0]             o_reg_rdata,
  output logic                        o_reg_hit,
  // pointer pair increment/decrement by pointer instructions
  input  wire logic                   i_ptr_upd,
  input  wire logic [1:0]             i_ptr_sel,
  input  wire logic [15:0]            i_ptr_new,
  output logic      [15:0]            o_ptr_x,
  output logic      [15:0]            o_ptr_y,
  output logic      [15:0]            o_ptr_z,
  // stack pointer i/o space access
  input  wire logic                   i_sp_wr_low,
  input  wire logic                   i_sp_wr_high,
  input  wire logic [7:0]             i_sp_wdata,
  input  wire csi_pkg::csi_stack_op_t i_stack_op,
  output logic      [15:0]            o_stack_ptr,
  // status flags register access
  input  wire logic                   i_status_flags_register_wr,
  input  wire logic [7:0]             i_status_flags_register_wdata,
  input  wire logic [6:0]             i_alu_flags,
  input  wire logic                   i_alu_flags_we,
  input  wire csi_pkg::csi_gi_op_t    i_gi_op,
  output logic      [7:0]             o_status_flags_register,
  // sequencer handshake
  input  wire logic                   i_instr_done,
  input  wire logic                   i_asleep,
  input  wire logic                   i_wake_done,
  // interrupt sources
  input  wire logic [NUM_SRC-1:0]     i_src_event,
  input  wire logic [NUM_SRC-1:0]     i_src_level,
  input  wire logic [NUM_SRC-1:0]     i_src_is_level,
  input  wire logic [NUM_SRC-1:0]     i_src_enable,
  input  wire logic                   i_flag_wr,
  input  wire logic [NUM_SRC-1:0]     i_flag_wdata,
  output logic      [NUM_SRC-1:0]     o_flags,
  // entry / exit control toward the sequencer
  output logic                        o_irq_busy,
  output logic                        o_push_pc,
  output logic                        o_pop_pc,
  output logic                        o_vector_load,
  output logic      [15:0]            o_vector_addr
);
  import csi_pkg::*;

  if (NUM_SRC < 1 || NUM_SRC > 16) begin : g_num_src_check
    $error("NUM_SRC out of range");
  end

  typedef enum logic [1:0] {ST_RUN, ST_ENTRY, ST_EXIT} csi_state_t;

  logic [7:0]         regs_reg [NUM_WORK_REGS];
  logic [15:0]        sp_reg;
  logic [7:0]         status_flags_register_reg;
  logic [NUM_SRC-1:0] flag_reg;
  csi_state_t         state_reg;
  logic [3:0]         cnt_reg;
  logic               hold_reg;
  logic [NUM_SRC-1:0] win_reg;
  logic [15:0]        vec_reg;
  logic               push_reg;
  logic               pop_reg;
  logic               load_reg;
  logic               busy_reg;
  logic [7:0]         rdata_reg;
  logic               hit_reg;

  // request qualification and fixed priority
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] win;
  logic               any_req;
  logic               gi_eff;
  logic               take;
  always_comb begin
    req = '0;
    win = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      req[i] = i_src_enable[i] && (i_src_is_level[i] ? i_src_level[i] : flag_reg[i]);
    end
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) win = NUM_SRC'(1) << i;
    end
  end
  assign any_req = |req;
  // a disable in this very cycle kills the take
  assign gi_eff  = status_flags_register_reg[GLOBAL_EN_BIT] && (i_gi_op != CSI_GI_CLEAR);
  assign take    = (state_reg == ST_RUN) && i_instr_done && !hold_reg && gi_eff && any_req
                   && (!i_asleep || i_wake_done);

  function automatic logic [15:0] vec_of(input logic [NUM_SRC-1:0] one_hot);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (one_hot[i]) v = VEC_ADDRS[i*16 +: 16];
    end
    return v;
  endfunction

  // working registers, including the pointer pairs
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < NUM_WORK_REGS; i++) regs_reg[i] <= 8'h00;
    end else begin
      if (i_reg_we && i_reg_addr < REG_SPACE_END) begin
        regs_reg[i_reg_addr[4:0]] <= i_reg_wdata;
      end
      if (i_ptr_upd) begin
        case (i_ptr_sel)
          2'h0: begin
            regs_reg[PTR_X_LOW_IDX]  <= i_ptr_new[7:0];
            regs_reg[PTR_X_HIGH_IDX] <= i_ptr_new[15:8];
          end
          2'h1: begin
            regs_reg[PTR_Y_LOW_IDX]  <= i_ptr_new[7:0];
            regs_reg[PTR_Y_HIGH_IDX] <= i_ptr_new[15:8];
          end
          default: begin
            regs_reg[PTR_Z_LOW_IDX]  <= i_ptr_new[7:0];
            regs_reg[PTR_Z_HIGH_IDX] <= i_ptr_new[15:8];
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= 8'h00;
      hit_reg   <= 1'b0;
    end else begin
      hit_reg   <= i_reg_addr < REG_SPACE_END;
      rdata_reg <= (i_reg_addr < REG_SPACE_END) ? regs_reg[i_reg_addr[4:0]] : 8'h00;
    end
  end

  // stack pointer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sp_reg <= SP_RESET;
    end else if (state_reg == ST_ENTRY && cnt_reg == 4'h0) begin
      sp_reg <= sp_reg - SP_STEP_ADDR;
    end else if (state_reg == ST_EXIT && cnt_reg == 4'h0) begin
      sp_reg <= sp_reg + SP_STEP_ADDR;
    end else if (i_sp_wr_low || i_sp_wr_high) begin
      if (i_sp_wr_low)  sp_reg[7:0]  <= i_sp_wdata;
      if (i_sp_wr_high) sp_reg[15:8] <= i_sp_wdata;
    end else begin
      case (i_stack_op)
        CSI_OP_PUSH: sp_reg <= sp_reg - SP_STEP_BYTE;
        CSI_OP_POP:  sp_reg <= sp_reg + SP_STEP_BYTE;
        CSI_OP_CALL: sp_reg <= sp_reg - SP_STEP_ADDR;
        CSI_OP_RET:  sp_reg <= sp_reg + SP_STEP_ADDR;
        default:     sp_reg <= sp_reg;
      endcase
    end
  end

  // status flags: only the global enable is touched by entry and exit
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_flags_register_reg <= 8'h00;
    end else begin
      if (i_status_flags_register_wr) begin
        status_flags_register_reg <= i_status_flags_register_wdata;
      end else if (i_alu_flags_we) begin
        status_flags_register_reg[6:0] <= i_alu_flags;
      end
      if (take) begin
        status_flags_register_reg[GLOBAL_EN_BIT] <= 1'b0;
      end else if (state_reg == ST_EXIT && cnt_reg == 4'h0) begin
        status_flags_register_reg[GLOBAL_EN_BIT] <= 1'b1;
      end else if (i_gi_op == CSI_GI_SET) begin
        status_flags_register_reg[GLOBAL_EN_BIT] <= 1'b1;
      end else if (i_gi_op == CSI_GI_CLEAR) begin
        status_flags_register_reg[GLOBAL_EN_BIT] <= 1'b0;
      end
    end
  end

  // flags: a new event beats any clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flag_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (i_src_event[i] && !i_src_is_level[i]) begin
          flag_reg[i] <= 1'b1;
        end else if (take && win[i] && !i_src_is_level[i]) begin
          flag_reg[i] <= 1'b0;
        end else if (i_flag_wr && i_flag_wdata[i]) begin
          flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // one-instruction hold after exit or after the enable instruction
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_reg <= 1'b0;
    end else if (state_reg == ST_EXIT && cnt_reg == 4'h0) begin
      hold_reg <= 1'b1;
    end else if (i_gi_op == CSI_GI_SET && !status_flags_register_reg[GLOBAL_EN_BIT]) begin
      hold_reg <= 1'b1;
    end else if (i_instr_done && state_reg == ST_RUN) begin
      hold_reg <= 1'b0;
    end
  end

  // entry / exit sequencer; the core clock is never divided
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= ST_RUN;
      cnt_reg   <= 4'h0;
      win_reg   <= '0;
      vec_reg   <= 16'h0000;
      push_reg  <= 1'b0;
      pop_reg   <= 1'b0;
      load_reg  <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      load_reg <= 1'b0;
      case (state_reg)
        ST_RUN: begin
          if (take) begin
            state_reg <= ST_ENTRY;
            busy_reg  <= 1'b1;
            win_reg   <= win;
            vec_reg   <= vec_of(win);
            push_reg  <= 1'b1;
            cnt_reg   <= 4'(i_asleep ? ENTRY_CYCLES + WAKE_EXTRA_CYCLES - 1
                                     : ENTRY_CYCLES - 1);
          end else if (i_stack_op == CSI_OP_INTERRUPT_EXIT_INSTR && i_instr_done) begin
            state_reg <= ST_EXIT;
            busy_reg  <= 1'b1;
            pop_reg   <= 1'b1;
            cnt_reg   <= 4'(EXIT_CYCLES - 1);
          end
        end
        ST_ENTRY: begin
          if (cnt_reg == 4'h0) begin
            state_reg <= ST_RUN;
            busy_reg  <= 1'b0;
            push_reg  <= 1'b0;
            load_reg  <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_EXIT: begin
          if (cnt_reg == 4'h0) begin
            state_reg <= ST_RUN;
            busy_reg  <= 1'b0;
            pop_reg   <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  assign o_reg_rdata   = rdata_reg;
  assign o_reg_hit     = hit_reg;
  assign o_ptr_x       = {regs_reg[PTR_X_HIGH_IDX], regs_reg[PTR_X_LOW_IDX]};
  assign o_ptr_y       = {regs_reg[PTR_Y_HIGH_IDX], regs_reg[PTR_Y_LOW_IDX]};
  assign o_ptr_z       = {regs_reg[PTR_Z_HIGH_IDX], regs_reg[PTR_Z_LOW_IDX]};
  assign o_stack_ptr   = sp_reg;
  assign o_status_flags_register        = status_flags_register_reg;
  assign o_flags       = flag_reg;
  assign o_irq_busy    = busy_reg;
  assign o_push_pc     = push_reg;
  assign o_pop_pc      = pop_reg;
  assign o_vector_load = load_reg;
  assign o_vector_addr = vec_reg;

  // checks
  a_entry_clears_gie: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take |=> !status_flags_register_reg[GLOBAL_EN_BIT]) else $error("global enable not cleared on entry");
  a_entry_sp_down: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (take && !i_asleep) |=> ##4 (sp_reg == $past(sp_reg, 5) - SP_STEP_ADDR))
    else $error("entry did not lower stack pointer by two");
  a_entry_len: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (take && !i_asleep) |=> o_push_pc [*4] ##1 o_vector_load)
    else $error("entry not four cycles");
  a_wake_len: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (take && i_asleep) |=> o_push_pc [*8] ##1 o_vector_load)
    else $error("wake entry not eight cycles");
  a_exit_sets_gie: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_pop_pc) |=> ##3 status_flags_register_reg[GLOBAL_EN_BIT]) else $error("exit did not set enable");
  a_cli_blocks: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_gi_op == CSI_GI_CLEAR) |-> !take) else $error("interrupt taken with disable");
  a_needs_enable: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take |-> (|(win & i_src_enable)) && status_flags_register_reg[GLOBAL_EN_BIT])
    else $error("disabled source taken");
  a_flag_cleared: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (take && |(win & ~i_src_is_level & ~i_src_event)) |=> !(|(flag_reg & $past(win))))
    else $error("flag not cleared on vectoring");
  a_push_one: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state_reg == ST_RUN && !take && !i_sp_wr_low && !i_sp_wr_high && i_stack_op == CSI_OP_PUSH)
    |=> sp_reg == $past(sp_reg) - SP_STEP_BYTE) else $error("push step wrong");
  a_hold_after_exit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state_reg == ST_EXIT && cnt_reg == 4'h0) |=> !take) else $error("no instruction after exit");

  c_entry: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_vector_load);
  c_exit:  cover property (@(posedge i_clk) disable iff (!i_rst_b) $fell(o_pop_pc));
  c_wake:  cover property (@(posedge i_clk) disable iff (!i_rst_b) take && i_asleep);
endmodule

// ### csi_pkg.sv
package csi_pkg;
  // register file and pointer pairs
  localparam int          NUM_WORK_REGS   = 32;
  localparam logic [4:0]  PTR_X_LOW_IDX   = 5'h1A;
  localparam logic [4:0]  PTR_X_HIGH_IDX  = 5'h1B;
  localparam logic [4:0]  PTR_Y_LOW_IDX   = 5'h1C;
  localparam logic [4:0]  PTR_Y_HIGH_IDX  = 5'h1D;
  localparam logic [4:0]  PTR_Z_LOW_IDX   = 5'h1E;
  localparam logic [4:0]  PTR_Z_HIGH_IDX  = 5'h1F;
  // data space: registers occupy addresses below this
  localparam logic [15:0] REG_SPACE_END   = 16'h0020;
  // stack pointer reset value (top of data memory), used as parameter default
  localparam logic [15:0] TOP_OF_DATA_MEMORY = 16'h02FF;
  // status register bit of the global enable
  localparam int          GLOBAL_EN_BIT   = 7;
  // timing in core cycles (core clock undivided)
  localparam int          ENTRY_CYCLES    = 4;
  localparam int          EXIT_CYCLES     = 4;
  localparam int          WAKE_EXTRA_CYCLES = 4;
  // stack pointer steps
  localparam logic [15:0] SP_STEP_BYTE    = 16'h0001;
  localparam logic [15:0] SP_STEP_ADDR    = 16'h0002;

  typedef enum logic [2:0] {
    CSI_OP_NONE,
    CSI_OP_PUSH,
    CSI_OP_POP,
    CSI_OP_CALL,
    CSI_OP_RET,
    CSI_OP_INTERRUPT_EXIT_INSTR
  } csi_stack_op_t;

  typedef enum logic [1:0] {
    CSI_GI_NONE,
    CSI_GI_SET,
    CSI_GI_CLEAR
  } csi_gi_op_t;
endpackage

// ### csi_seq_model.sv
module csi_seq_model (
  input  wire logic i_rst_b,
  input  wire logic i_irq_busy,
  input  wire logic i_stall,
  output logic      o_instr_done
);
  timeunit 1ns;
  timeprecision 100ps;
  // back-to-back single-cycle instructions; stall stretches one into a multi-cycle one
  assign o_instr_done = i_rst_b && !i_irq_busy && !i_stall;
endmodule

// ### tb_cpu_stack_and_interrupt_entry.sv
module tb_cpu_stack_and_interrupt_entry;
  timeunit 1ns;
  timeprecision 100ps;
  import csi_pkg::*;
  logic          i_clk = 0, i_rst_b = 0, reg_we = 0, ptr_upd = 0, sp_lo = 0, sp_hi = 0;
  logic          status_flags_register_wr = 0, flag_wr = 0, asleep = 0, wake = 0, stall = 0, done;
  logic [15:0]   reg_addr = '0, ptr_new = '0, exp_sp, px, py, pz, sp, vaddr;
  logic [7:0]    reg_wdata = '0, sp_wdata = '0, status_flags_register_wdata = '0, flag_wdata = '0;
  logic [7:0]    ev = '0, lvl = '0, is_lvl = '0, en = '0, rdata, status_flags_register, flags;
  logic [1:0]    ptr_sel = '0;
  logic [6:0]    alu_f = '0;
  logic          alu_we = 0;
  logic          hit, busy, push, pop, vload;
  csi_stack_op_t sop = CSI_OP_NONE;
  csi_gi_op_t    gop = CSI_GI_NONE;
  csi_stack_op_t ops [4] = '{CSI_OP_PUSH, CSI_OP_POP, CSI_OP_CALL, CSI_OP_RET};
  logic [15:0]   dlt [4] = '{16'hFFFF, 16'h0001, 16'hFFFE, 16'h0002};
  int            n_fail = 0, check_count = 0, k;

  csi_core dut_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_we(reg_we), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata), .o_reg_hit(hit),
    .i_ptr_upd(ptr_upd), .i_ptr_sel(ptr_sel), .i_ptr_new(ptr_new),
    .o_ptr_x(px), .o_ptr_y(py), .o_ptr_z(pz),
    .i_sp_wr_low(sp_lo), .i_sp_wr_high(sp_hi), .i_sp_wdata(sp_wdata),
    .i_stack_op(sop), .o_stack_ptr(sp), .i_status_flags_register_wr(status_flags_register_wr), .i_status_flags_register_wdata(status_flags_register_wdata),
    .i_alu_flags(alu_f), .i_alu_flags_we(alu_we), .i_gi_op(gop), .o_status_flags_register(status_flags_register),
    .i_instr_done(done), .i_asleep(asleep), .i_wake_done(wake),
    .i_src_event(ev), .i_src_level(lvl), .i_src_is_level(is_lvl), .i_src_enable(en),
    .i_flag_wr(flag_wr), .i_flag_wdata(flag_wdata), .o_flags(flags),
    .o_irq_busy(busy), .o_push_pc(push), .o_pop_pc(pop),
    .o_vector_load(vload), .o_vector_addr(vaddr)
  );

  csi_seq_model seq_u (
    .i_rst_b(i_rst_b), .i_irq_busy(busy), .i_stall(stall), .o_instr_done(done)
  );

  initial begin
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic tick(int n = 1);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic no_take(int n);
    repeat (n) begin
      tick();
      chk("push_pc_idle", 16'(push), 16'h0000);
    end
  endtask

  // waits boundedly for push_pc or pop_pc, then counts how long it stands
  task automatic run(bit use_pop, output int len);
    int t;
    t = 0;
    while ((use_pop ? pop : push) !== 1'b1) begin
      tick();
      t++;
      if (t > 40) begin
        n_fail++;
        finish_test();
      end
    end
    chk("irq_busy", 16'(busy), 16'h0001);
    len = 0;
    while ((use_pop ? pop : push) === 1'b1 && len < 12) begin
      tick();
      len++;
    end
  endtask

  task automatic entry(int len, logic [15:0] vec);
    int n;
    run(1'b0, n);
    chk("push_len", 16'(n), 16'(len));
    chk("vector_load", 16'(vload), 16'h0001);
    chk("vector_addr", vaddr, vec);
    exp_sp = exp_sp - SP_STEP_ADDR;
    chk("sp_entry", sp, exp_sp);
    chk("gi_entry", 16'(status_flags_register[GLOBAL_EN_BIT]), 16'h0000);
  endtask

  task automatic gi(csi_gi_op_t g);
    gop = g;
    tick();
    gop = CSI_GI_NONE;
  endtask

  initial begin
    tick(5);
    i_rst_b = 1;
    tick();
    chk("sp_reset", sp, TOP_OF_DATA_MEMORY);
    chk("status_flags_register_reset", 16'(status_flags_register), 16'h0000);
    // stack must sit above the extended i/o area before calls or interrupts
    sp_wdata = 8'h01;
    sp_hi = 1;
    tick();
    sp_hi = 0;
    sp_wdata = 8'h00;
    sp_lo = 1;
    tick();
    sp_lo = 0;
    exp_sp = 16'h0100;
    chk("sp_write", sp, exp_sp);
    foreach (ops[i]) begin
      sop = ops[i];
      tick();
      sop = CSI_OP_NONE;
      exp_sp = exp_sp + dlt[i];
      chk("sp_op", sp, exp_sp);
    end
    reg_we = 1;
    for (int i = 0; i < 6; i++) begin
      reg_addr = 16'(PTR_X_LOW_IDX) + 16'(i);
      reg_wdata = 8'hA0 + 8'(i);
      tick();
    end
    reg_we = 0;
    chk("ptr_x", px, 16'hA1A0);
    chk("ptr_y", py, 16'hA3A2);
    chk("ptr_z", pz, 16'hA5A4);
    reg_addr = 16'h001B;
    tick();
    chk("reg_rdata", 16'(rdata), 16'h00A1);
    chk("reg_hit", 16'(hit), 16'h0001);
    reg_addr = REG_SPACE_END;
    tick();
    chk("io_hit", 16'(hit), 16'h0000);
    ptr_upd = 1;
    for (int s = 0; s < 3; s++) begin
      ptr_sel = 2'(s);
      ptr_new = 16'h1234 + 16'(s);
      tick();
    end
    ptr_upd = 0;
    chk("ptr_x_load", px, 16'h1234);
    chk("ptr_y_load", py, 16'h1235);
    chk("ptr_z_load", pz, 16'h1236);
    status_flags_register_wdata = 8'h15;
    status_flags_register_wr = 1;
    tick();
    status_flags_register_wr = 0;
    en = 8'h0A;
    ev = 8'h0A;
    tick();
    ev = 8'h00;
    no_take(3);
    chk("flags_kept", 16'(flags), 16'h000A);
    gi(CSI_GI_SET);
    no_take(1);
    entry(4, 16'h0004);
    chk("status_flags_register_entry", 16'(status_flags_register), 16'h0015);
    chk("flag_hw_clear", 16'(flags), 16'h0008);
    // the handler changes the arithmetic flags; exit must not restore them
    alu_f = 7'h2A;
    alu_we = 1;
    tick();
    alu_we = 0;
    chk("status_flags_register_handler", 16'(status_flags_register), 16'h002A);
    sop = CSI_OP_INTERRUPT_EXIT_INSTR;
    tick();
    sop = CSI_OP_NONE;
    run(1'b1, k);
    chk("pop_len", 16'(k), 16'(EXIT_CYCLES));
    exp_sp = exp_sp + SP_STEP_ADDR;
    chk("sp_exit", sp, exp_sp);
    chk("status_flags_register_exit", 16'(status_flags_register), 16'h00AA);
    chk("push_after_exit", 16'(push), 16'h0000);
    no_take(1);
    entry(4, 16'h0008);
    chk("flags_none", 16'(flags), 16'h0000);
    en = 8'h00;
    ev = 8'h60;
    tick();
    ev = 8'h00;
    flag_wdata = 8'h20;
    flag_wr = 1;
    tick();
    flag_wr = 0;
    chk("flag_w1c", 16'(flags), 16'h0040);
    // pending request and disable in one cycle: the disable must win
    en = 8'h04;
    ev = 8'h04;
    tick();
    ev = 8'h00;
    // a whole-register write sets the enable without the one-instruction hold
    status_flags_register_wdata = 8'h95;
    status_flags_register_wr = 1;
    tick();
    status_flags_register_wr = 0;
    gop = CSI_GI_CLEAR;
    tick();
    gop = CSI_GI_NONE;
    no_take(5);
    chk("gi_clear", 16'(status_flags_register[GLOBAL_EN_BIT]), 16'h0000);
    flag_wdata = 8'h44;
    flag_wr = 1;
    tick();
    flag_wr = 0;
    chk("flag_w1c_all", 16'(flags), 16'h0000);
    is_lvl = 8'h10;
    lvl = 8'h10;
    en = 8'h00;
    gi(CSI_GI_SET);
    no_take(3);
    lvl = 8'h00;
    tick();
    en = 8'h10;
    no_take(4);
    lvl = 8'h10;
    entry(4, 16'h000A);
    lvl = 8'h00;
    en = 8'h01;
    gi(CSI_GI_SET);
    tick();
    stall = 1;
    ev = 8'h01;
    tick();
    ev = 8'h00;
    no_take(5);
    stall = 0;
    entry(4, 16'h0002);
    gi(CSI_GI_SET);
    asleep = 1;
    ev = 8'h01;
    tick();
    ev = 8'h00;
    no_take(4);
    wake = 1;
    entry(ENTRY_CYCLES + WAKE_EXTRA_CYCLES, 16'h0002);
    asleep = 0;
    wake = 0;
    finish_test();
  end
endmodule
